// ---- rtl/pcef_pkg.sv ----
// Constants shared by the counter event filter and its snapshot store.
package pcef_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] CFG_BASE  = 12'h400;
  localparam logic [11:0] CFG_LAST  = 12'h4FF;
  localparam logic [11:0] SNAP_BASE = 12'h600;
  localparam logic [11:0] SNAP_LAST = 12'h7FF;

  // ****************************************************************
  // Configuration word fields
  // ****************************************************************
  localparam int OVERFLOW_SNAPSHOT_TRIGGER_BIT = 31;
  localparam int SEC_BIT    = 30;
  localparam int SPAN_BIT   = 29;
  localparam int PNS_BIT    = 18;
  localparam int PMGF_BIT   = 17;
  localparam int PARTF_BIT  = 16;
  localparam int EVT_FIELD_W = 16;
  localparam logic [31:0] OVERFLOW_SNAPSHOT_TRIGGER_MASK = 32'h8000_0000;
  localparam logic [31:0] FILTER_MASK = 32'h6007_0000;

  // ****************************************************************
  // Stream match word fields in partition mode
  // ****************************************************************
  localparam int PART_LSB = 0;
  localparam int PART_W   = 16;
  localparam int PMG_LSB  = 16;
  localparam int PMG_W    = 8;

  // ****************************************************************
  // Reset values and sizes
  // ****************************************************************
  localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
  localparam logic [63:0] SNAP_RESET  = 64'h0000_0000_0000_0000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  localparam int NARROW_CNT_MAX = 32;
  localparam int MAX_COUNTERS   = 64;

endpackage

// ---- rtl/pcef_snap_mem.sv ----
// Snapshot store: captures every counter at once, one registered read port.
`timescale 1ns/1ps
`default_nettype none

module pcef_snap_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 32
) (
  input  wire logic                        clock_i,
  input  wire logic                        rst_b_i,
  input  wire logic                        capture_i,
  input  wire logic [DEPTH-1:0][WIDTH-1:0] values_i,
  input  wire logic                        rd_en_i,
  input  wire logic [5:0]                  rd_idx_i,
  input  wire logic                        rd_hi_i,
  output logic      [31:0]                 rd_data_o
);

  logic [DEPTH-1:0][WIDTH-1:0] mem;
  logic [DEPTH-1:0][WIDTH-1:0] next_mem;
  logic [31:0]                 next_rd_data;
  logic [63:0]                 wide;

  always_comb begin
    next_mem = mem;
    if (capture_i) begin
      next_mem = values_i;
    end
    wide = 64'h0000_0000_0000_0000;
    next_rd_data = 32'h0000_0000;
    if (rd_en_i) begin
      wide = 64'(mem[rd_idx_i]);
      next_rd_data = rd_hi_i ? wide[63:32] : wide[31:0];
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= WIDTH'(pcef_pkg::SNAP_RESET);
      end
      rd_data_o <= pcef_pkg::RDATA_RESET;
    end else begin
      mem       <= next_mem;
      rd_data_o <= next_rd_data;
    end
  end

endmodule

`default_nettype wire

// ---- rtl/pcef_top.sv ----
// Per-counter event selection, filtering and snapshot register bank.
`timescale 1ns/1ps
`default_nettype none

module pcef_top #(
  parameter int NUM_CNT = 8,
  parameter int EVT_W   = 16,
  parameter int CNT_W   = 32,
  parameter int SID_W   = 32
) (
  input  wire logic                          clock_i,
  input  wire logic                          rst_b_i,
  input  wire logic                          reg_req_i,
  input  wire logic                          reg_we_i,
  input  wire logic [11:0]                   reg_addr_i,
  input  wire logic [31:0]                   reg_wdata_i,
  output logic                               reg_ack_o,
  output logic      [31:0]                   reg_rdata_o,
  input  wire logic                          security_impl_i,
  input  wire logic                          secure_observe_i,
  input  wire logic                          shared_filter_select_i,
  input  wire logic                          capture_impl_i,
  input  wire logic                          group_enable_i,
  input  wire logic [NUM_CNT-1:0]            counter_enable_i,
  input  wire logic [NUM_CNT-1:0][31:0]      stream_match_register_i,
  input  wire logic [NUM_CNT-1:0][CNT_W-1:0] event_count_value_i,
  input  wire logic [NUM_CNT-1:0]            counter_overflow_i,
  input  wire logic                          capture_request_i,
  input  wire logic                          event_valid_i,
  input  wire logic [15:0]                   event_code_i,
  input  wire logic [SID_W-1:0]              event_sid_i,
  input  wire logic                          event_secure_i,
  input  wire logic                          event_sid_filterable_i,
  input  wire logic                          event_part_filterable_i,
  input  wire logic [15:0]                   event_partition_match_value_i,
  input  wire logic [7:0]                    event_pmg_i,
  input  wire logic                          event_part_ns_i,
  output logic      [NUM_CNT-1:0]            count_increment_o,
  output logic                               snapshot_taken_o
);

  // ****************************************************************
  // Constants and helper functions
  // ****************************************************************
  localparam logic [31:0] EVT_MASK = 32'((64'h1 << EVT_W) - 64'h1);
  localparam logic [31:0] WR_MASK  =
    pcef_pkg::OVERFLOW_SNAPSHOT_TRIGGER_MASK | pcef_pkg::FILTER_MASK | EVT_MASK;
  localparam bit WIDE = (CNT_W > pcef_pkg::NARROW_CNT_MAX);

  // Visible form of a stored word: what software reads and what the
  // filters obey are kept identical by routing both through here.
  function automatic logic [31:0] cfg_view(input logic [31:0] word,
                                           input logic        is_zero,
                                           input logic        shared,
                                           input logic        so,
                                           input logic        sec_impl,
                                           input logic        cap_impl);
    logic [31:0] v;
    v = word & WR_MASK;
    if (!sec_impl) begin
      v[pcef_pkg::SEC_BIT] = 1'b0;
    end
    if (!so) begin
      v[pcef_pkg::PNS_BIT] = 1'b0;
    end
    if (shared && !is_zero) begin
      v = v & ~pcef_pkg::FILTER_MASK;
    end
    if (!cap_impl) begin
      v[pcef_pkg::OVERFLOW_SNAPSHOT_TRIGGER_BIT] = 1'b0;
    end
    return v;
  endfunction

  // Span form: trailing ones of the value plus the next bit are ignored,
  // so an all-ones value ignores every bit and matches any stream.
  function automatic logic sid_match(input logic             span,
                                     input logic [SID_W-1:0] value,
                                     input logic [SID_W-1:0] sid);
    logic [SID_W-1:0] ignore;
    ignore = {SID_W{1'b0}};
    if (span) begin
      ignore = value ^ (value + {{(SID_W-1){1'b0}}, 1'b1});
    end
    return ((value ^ sid) & ~ignore) == {SID_W{1'b0}};
  endfunction

  // Registers of counters that are not built read zero and drop writes.
  function automatic logic slot_ok(input logic [5:0] idx);
    return 32'(idx) < NUM_CNT;
  endfunction

  // Aligned word inside one register window.
  function automatic logic in_window(input logic [11:0] addr,
                                     input logic [11:0] base,
                                     input logic [11:0] last);
    return (addr >= base) && (addr <= last) && (addr[1:0] == 2'h0);
  endfunction

  // Partition mode: each enabled field must match, and the event's
  // partition space must be the one the match values belong to.
  function automatic logic part_match(input logic [31:0] cfg,
                                      input logic [31:0] smr,
                                      input logic [15:0] partition_match_value,
                                      input logic [7:0]  monitor_group_match_value,
                                      input logic        ev_ns,
                                      input logic        so);
    logic part_hit;
    logic pmg_hit;
    logic ns_want;
    part_hit = !cfg[pcef_pkg::PARTF_BIT] ||
               partition_match_value == smr[pcef_pkg::PART_LSB +: pcef_pkg::PART_W];
    pmg_hit  = !cfg[pcef_pkg::PMGF_BIT] ||
               monitor_group_match_value == smr[pcef_pkg::PMG_LSB +: pcef_pkg::PMG_W];
    // Values are non-secure whenever observation is off.
    ns_want  = so ? cfg[pcef_pkg::PNS_BIT] : 1'b1;
    return part_hit && pmg_hit && (ev_ns == ns_want);
  endfunction

  function automatic logic stream_ok(input logic [31:0]      cfg,
                                     input logic [SID_W-1:0] value,
                                     input logic [SID_W-1:0] sid,
                                     input logic             ev_sec,
                                     input logic             so);
    logic sec_eff;
    sec_eff = cfg[pcef_pkg::SEC_BIT] && so;
    // A match-all span still honours the chosen stream space.
    return (ev_sec == sec_eff) &&
           sid_match(cfg[pcef_pkg::SPAN_BIT], value, sid);
  endfunction

  // ****************************************************************
  // Global controls
  // ****************************************************************
  // These come from the group's control and capability registers,
  // which live outside this bank; they are taken as steady levels.
  logic have_security;
  logic observe_secure;
  logic shared_filters;
  logic have_capture;

  always_comb begin
    have_security  = security_impl_i;
    observe_secure = secure_observe_i;
    shared_filters = shared_filter_select_i;
    have_capture   = capture_impl_i;
  end

  // ****************************************************************
  // Configuration storage and register access
  // ****************************************************************
  logic [NUM_CNT-1:0][31:0] cfg_q;
  logic [NUM_CNT-1:0][31:0] next_cfg;
  logic                     ack1;
  logic                     next_ack1;
  logic                     snap_sel1;
  logic                     next_snap_sel1;
  logic [31:0]              cfg_rd1;
  logic [31:0]              next_cfg_rd1;
  logic                     next_ack;
  logic [31:0]              next_rdata;
  logic                     cfg_hit;
  logic                     snap_hit;
  logic [5:0]               cfg_idx;
  logic [5:0]               snap_idx;
  logic                     snap_hi;
  logic                     snap_rd_en;
  logic [31:0]              wmask;
  logic [31:0]              snap_rd_data;

  // Every request is answered two edges after it is taken. The extra
  // stage lines the configuration read up with the registered read port
  // of the snapshot store, so one answer path serves both, at the cost
  // of one cycle of latency on configuration reads.
  always_comb begin
    cfg_hit  = in_window(reg_addr_i, pcef_pkg::CFG_BASE,
                         pcef_pkg::CFG_LAST);
    cfg_idx  = reg_addr_i[7:2];
    snap_hit = in_window(reg_addr_i, pcef_pkg::SNAP_BASE,
                         pcef_pkg::SNAP_LAST);
    if (WIDE) begin
      snap_idx = reg_addr_i[8:3];
      snap_hi  = reg_addr_i[2];
    end else begin
      snap_idx = reg_addr_i[7:2];
      snap_hi  = 1'b0;
      snap_hit = snap_hit && !reg_addr_i[8];
    end
    snap_rd_en = reg_req_i && !reg_we_i && snap_hit && have_capture &&
                 slot_ok(snap_idx);

    next_cfg = cfg_q;
    wmask = WR_MASK;
    if (shared_filters && cfg_idx != 6'h00) begin
      wmask = wmask & ~pcef_pkg::FILTER_MASK;
    end
    // Writes to snapshot space fall through here and are dropped.
    if (reg_req_i && reg_we_i && cfg_hit && slot_ok(cfg_idx)) begin
      next_cfg[cfg_idx] = (cfg_q[cfg_idx] & ~wmask) |
                          (reg_wdata_i & wmask);
    end

    next_ack1      = reg_req_i;
    next_snap_sel1 = snap_rd_en;
    next_cfg_rd1   = 32'h0000_0000;
    if (reg_req_i && !reg_we_i && cfg_hit && slot_ok(cfg_idx)) begin
      next_cfg_rd1 = cfg_view(cfg_q[cfg_idx], cfg_idx == 6'h00,
                              shared_filters, observe_secure,
                              have_security, have_capture);
    end
    next_ack   = ack1;
    next_rdata = snap_sel1 ? snap_rd_data : cfg_rd1;
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < NUM_CNT; i++) begin
        cfg_q[i] <= pcef_pkg::CFG_RESET;
      end
      ack1        <= 1'b0;
      snap_sel1   <= 1'b0;
      cfg_rd1     <= pcef_pkg::RDATA_RESET;
      reg_ack_o   <= 1'b0;
      reg_rdata_o <= pcef_pkg::RDATA_RESET;
    end else begin
      cfg_q       <= next_cfg;
      ack1        <= next_ack1;
      snap_sel1   <= next_snap_sel1;
      cfg_rd1     <= next_cfg_rd1;
      reg_ack_o   <= next_ack;
      reg_rdata_o <= next_rdata;
    end
  end

  // ****************************************************************
  // Event filtering per counter
  // ****************************************************************
  logic [NUM_CNT-1:0] hit;
  logic [NUM_CNT-1:0] ovf_capture_en;

  for (genvar n = 0; n < NUM_CNT; n++) begin : g_filter
    logic [31:0] own;
    logic [31:0] fcfg;
    logic [31:0] smr;
    logic        part_mode;
    logic        part_ok;
    logic        sid_ok;

    always_comb begin
      own = cfg_view(cfg_q[n], n == 0, shared_filters,
                     observe_secure, have_security, have_capture);
      if (shared_filters) begin
        fcfg = cfg_view(cfg_q[0], 1'b1, 1'b1, observe_secure,
                        have_security, have_capture);
        smr  = stream_match_register_i[0];
      end else begin
        fcfg = own;
        smr  = stream_match_register_i[n];
      end
      part_mode = fcfg[pcef_pkg::PARTF_BIT] ||
                  fcfg[pcef_pkg::PMGF_BIT];
      part_ok   = !event_part_filterable_i ||
                  part_match(fcfg, smr, event_partition_match_value_i, event_pmg_i,
                             event_part_ns_i, observe_secure);
      sid_ok    = !event_sid_filterable_i ||
                  stream_ok(fcfg, smr[SID_W-1:0], event_sid_i,
                            event_secure_i, observe_secure);
      hit[n] = event_valid_i && group_enable_i && counter_enable_i[n] &&
               (event_code_i ==
                own[pcef_pkg::EVT_FIELD_W-1:0]) &&
               (part_mode ? part_ok : sid_ok);
      ovf_capture_en[n] = own[pcef_pkg::OVERFLOW_SNAPSHOT_TRIGGER_BIT];
    end
  end

  // ****************************************************************
  // Capture and snapshot store
  // ****************************************************************
  // The read port reads the stored array before a capture rewrites it, so a read
  // taken in the capture cycle still returns the previous snapshot.
  logic capture_now;

  always_comb begin
    capture_now = have_capture && (capture_request_i ||
                  |(counter_overflow_i & ovf_capture_en));
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_increment_o <= {NUM_CNT{1'b0}};
      snapshot_taken_o  <= 1'b0;
    end else begin
      count_increment_o <= hit;
      snapshot_taken_o  <= capture_now;
    end
  end

  pcef_snap_mem #(
    .DEPTH (NUM_CNT),
    .WIDTH (CNT_W)
  ) u_snap (
    .clock_i   (clock_i),
    .rst_b_i   (rst_b_i),
    .capture_i (capture_now),
    .values_i  (event_count_value_i),
    .rd_en_i   (snap_rd_en),
    .rd_idx_i  (snap_idx),
    .rd_hi_i   (snap_hi),
    .rd_data_o (snap_rd_data)
  );

endmodule

`default_nettype wire

// ---- test/pcef_checker.sv ----
// Port-level assertions for the counter event filter bank.
`timescale 1ns/1ps
`default_nettype none

module pcef_checker #(
  parameter int NUM_CNT = 8
) (
  input wire logic               clock_i,
  input wire logic               rst_b_i,
  input wire logic               reg_req_i,
  input wire logic               reg_we_i,
  input wire logic [11:0]        reg_addr_i,
  input wire logic               reg_ack_o,
  input wire logic [31:0]        reg_rdata_o,
  input wire logic               security_impl_i,
  input wire logic               secure_observe_i,
  input wire logic               capture_impl_i,
  input wire logic               capture_request_i,
  input wire logic               group_enable_i,
  input wire logic [NUM_CNT-1:0] counter_enable_i,
  input wire logic               event_valid_i,
  input wire logic [NUM_CNT-1:0] count_increment_o,
  input wire logic               snapshot_taken_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  wire logic rd_cfg = reg_req_i && !reg_we_i && reg_addr_i[11:8] == 4'h4;

  a_ack_latency: assert property (reg_req_i |-> ##2 reg_ack_o)
    else $error("register answer not two cycles after request");
  a_no_stray_ack: assert property (!reg_req_i |-> ##2 !reg_ack_o)
    else $error("register answer without a request");
  a_write_rdata_zero: assert property (reg_req_i && reg_we_i |-> ##2 reg_rdata_o == 32'h0)
    else $error("write answered with nonzero data");
  a_reserved_reads_zero: assert property (rd_cfg |-> ##2 reg_rdata_o[28:19] == 10'h0)
    else $error("reserved configuration bits read nonzero");
  a_secure_bit_absent: assert property (rd_cfg && !security_impl_i |-> ##2 !reg_rdata_o[30])
    else $error("secure select reads one without security");
  a_pns_unobserved: assert property (rd_cfg && !secure_observe_i |-> ##2 !reg_rdata_o[18])
    else $error("partition space bit reads one while unobserved");
  a_capture_pulse: assert property (capture_impl_i && capture_request_i |=> snapshot_taken_o)
    else $error("capture request without snapshot");
  a_no_capture_impl: assert property (!capture_impl_i |=> !snapshot_taken_o)
    else $error("snapshot taken without capture support");
  a_idle_no_count: assert property (!event_valid_i || !group_enable_i |=> count_increment_o == '0)
    else $error("count without an enabled event");
  a_enable_gates: assert property (event_valid_i |=> (count_increment_o & ~$past(counter_enable_i)) == '0)
    else $error("disabled counter incremented");

  c_capture: cover property (capture_request_i && capture_impl_i);
  c_count: cover property (event_valid_i ##1 |count_increment_o);
  c_cfg_read: cover property (rd_cfg ##2 reg_ack_o);
endmodule

bind pcef_top pcef_checker #(.NUM_CNT(NUM_CNT)) u_chk (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .reg_req_i(reg_req_i),
  .reg_we_i(reg_we_i), .reg_addr_i(reg_addr_i), .reg_ack_o(reg_ack_o),
  .reg_rdata_o(reg_rdata_o), .security_impl_i(security_impl_i),
  .secure_observe_i(secure_observe_i), .capture_impl_i(capture_impl_i),
  .capture_request_i(capture_request_i), .group_enable_i(group_enable_i),
  .counter_enable_i(counter_enable_i), .event_valid_i(event_valid_i),
  .count_increment_o(count_increment_o),
  .snapshot_taken_o(snapshot_taken_o));
`default_nettype wire

// ---- test/pcef_counter_bank.sv ----
// Behavioural counter bank that the filter drives and snapshots.
`timescale 1ns/1ps
`default_nettype none

module pcef_counter_bank #(
  parameter int N = 4
) (
  input  wire logic              clock_i,
  input  wire logic              rst_b_i,
  input  wire logic [N-1:0]      inc_i,
  input  wire logic              load_i,
  input  wire logic [N-1:0][31:0] load_val_i,
  output logic      [N-1:0][31:0] value_o,
  output logic      [N-1:0]      ovf_o
);
  // Overflow is flagged in the same cycle the value shows the wrap.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      value_o <= '0;
      ovf_o <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        ovf_o[i] <= inc_i[i] && (&value_o[i]);
        value_o[i] <= load_i ? load_val_i[i] : value_o[i] + inc_i[i];
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/test_pcef_top.sv ----
// Self-checking bench for the counter event filter bank.
`timescale 1ns/1ps
`default_nettype none

module test_pcef_top;
  logic clock_i, rst_b_i, reg_req_i, reg_we_i, reg_ack_o, load;
  logic [11:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, seed;
  logic sec_impl, observe, shared, cap_impl, cap_req, ev_valid, ev_d;
  logic ev_sec, ev_sf, ev_pf, ev_ns;
  logic [3:0] cnt_en, inc, ovf;
  logic [15:0] ev_code, ev_part;
  logic [7:0] ev_pmg;
  logic [31:0] ev_sid;
  logic [3:0][31:0] smr, val, v;
  logic [31:0] rq[$];
  logic [31:0] eq[$];
  int fail_count, n_compared;

  pcef_top #(.NUM_CNT(4)) u_dut (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .reg_req_i(reg_req_i),
    .reg_we_i(reg_we_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_ack_o(reg_ack_o), .reg_rdata_o(reg_rdata_o),
    .security_impl_i(sec_impl), .secure_observe_i(observe),
    .shared_filter_select_i(shared), .capture_impl_i(cap_impl),
    .group_enable_i(1'b1), .counter_enable_i(cnt_en),
    .stream_match_register_i(smr), .event_count_value_i(val),
    .counter_overflow_i(ovf), .capture_request_i(cap_req),
    .event_valid_i(ev_valid), .event_code_i(ev_code), .event_sid_i(ev_sid),
    .event_secure_i(ev_sec), .event_sid_filterable_i(ev_sf),
    .event_part_filterable_i(ev_pf), .event_partition_match_value_i(ev_part),
    .event_pmg_i(ev_pmg), .event_part_ns_i(ev_ns),
    .count_increment_o(inc), .snapshot_taken_o());

  pcef_counter_bank #(.N(4)) u_bank (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .inc_i(inc), .load_i(load),
    .load_val_i(v), .value_o(val), .ovf_o(ovf));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Request stays up so that consecutive calls run back to back.
  task automatic reg_op(input logic we, input logic [11:0] a,
                        input logic [31:0] d, input logic [31:0] e);
    @(negedge clock_i);
    reg_req_i = 1'b1;
    reg_we_i = we;
    reg_addr_i = a;
    reg_wdata_i = d;
    rq.push_back(e);
  endtask

  task automatic ev(input logic [15:0] c, input logic [31:0] s,
                    input logic [3:0] f, input logic [15:0] p,
                    input logic [3:0] e);
    @(negedge clock_i);
    ev_valid = 1'b1;
    ev_code = c;
    ev_sid = s;
    {ev_sec, ev_sf, ev_pf, ev_ns} = f;
    ev_part = p;
    eq.push_back({28'h0, e});
  endtask

  task automatic idle(input int n);
    @(negedge clock_i);
    reg_req_i = 1'b0;
    ev_valid = 1'b0;
    cap_req = 1'b0;
    load = 1'b0;
    repeat (n) @(negedge clock_i);
  endtask

  always @(posedge clock_i) begin
    if (reg_ack_o === 1'b1)
      check(reg_rdata_o, rq.size() ? rq.pop_front() : 32'hDEAD_BEEF);
    if (ev_d)
      check({28'h0, inc}, eq.size() ? eq.pop_front() : 32'hDEAD_BEEF);
    ev_d <= ev_valid;
  end

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  initial begin
    {rst_b_i, reg_req_i, reg_we_i, ev_valid, cap_req, load} = '0;
    ev_pmg = 8'h00;
    {sec_impl, observe, cap_impl, shared, cnt_en} = 8'hEF;
    {reg_addr_i, reg_wdata_i, ev_code, ev_sid, ev_part} = '0;
    {ev_sec, ev_sf, ev_pf, ev_ns} = 4'h0;
    seed = 32'h29;
    v = '0;
    smr = {32'hFFFF_FFFF, 32'h0000_0012, 32'h3, 32'h25};
    repeat (20) @(negedge clock_i);
    rst_b_i = 1'b1;
    reg_op(1'b1, 12'h400, 32'hFFFF_FFFF, 32'h0);
    reg_op(1'b0, 12'h400, 32'h0, 32'hE007_FFFF);
    reg_op(1'b1, 12'h400, 32'h0000_0010, 32'h0);
    reg_op(1'b1, 12'h404, 32'h2000_0011, 32'h0);
    reg_op(1'b1, 12'h408, 32'h0005_0012, 32'h0);
    reg_op(1'b1, 12'h40C, 32'h6000_0013, 32'h0);
    idle(2);
    ev(16'h10, 32'h25, 4'h6, 16'h0, 4'h1);
    ev(16'h10, 32'h26, 4'h6, 16'h0, 4'h0);
    ev(16'h10, 32'h25, 4'hE, 16'h0, 4'h0);
    ev(16'h10, rnd(), 4'h2, 16'h0, 4'h1);
    ev(16'h11, 32'h6, 4'h6, 16'h0, 4'h2);
    ev(16'h11, 32'h9, 4'h6, 16'h0, 4'h0);
    ev(16'h12, rnd(), 4'h7, 16'h12, 4'h4);
    ev(16'h12, 32'h0, 4'h7, 16'h13, 4'h0);
    ev(16'h12, 32'h0, 4'h6, 16'h12, 4'h0);
    ev(16'h12, 32'h0, 4'h5, 16'h13, 4'h4);
    ev(16'h13, rnd(), 4'hE, 16'h0, 4'h8);
    ev(16'h13, rnd(), 4'h6, 16'h0, 4'h0);
    idle(2);
    cnt_en = 4'hB;
    ev(16'h12, 32'h0, 4'h7, 16'h12, 4'h0);
    idle(2);
    cnt_en = 4'hF;
    reg_op(1'b1, 12'h408, 32'h0006_0012, 32'h0);
    idle(1);
    ev(16'h12, 32'h0, 4'h7, 16'h77, 4'h4);
    idle(1);
    ev_pmg = 8'h03;
    ev(16'h12, 32'h0, 4'h7, 16'h77, 4'h0);
    idle(2);
    v = {rnd(), rnd(), rnd(), rnd()};
    load = 1'b1;
    @(negedge clock_i);
    load = 1'b0;
    cap_req = 1'b1;
    idle(2);
    for (int i = 0; i < 4; i++)
      reg_op(1'b0, 12'h600 + 12'(4 * i), 32'h0, v[i]);
    reg_op(1'b1, 12'h600, 32'h1234_5678, 32'h0);
    reg_op(1'b0, 12'h600, 32'h0, v[0]);
    reg_op(1'b1, 12'h400, 32'h8000_0010, 32'h0);
    idle(2);
    v[0] = 32'hFFFF_FFFF;
    load = 1'b1;
    ev(16'h10, 32'h25, 4'h6, 16'h0, 4'h1);
    load = 1'b0;
    idle(4);
    reg_op(1'b0, 12'h600, 32'h0, 32'h0);
    reg_op(1'b0, 12'h604, 32'h0, v[1]);
    idle(1);
    {cap_impl, observe} = 2'b00;
    idle(2);
    reg_op(1'b0, 12'h604, 32'h0, 32'h0);
    reg_op(1'b1, 12'h41C, 32'hFFFF_FFFF, 32'h0);
    reg_op(1'b0, 12'h41C, 32'h0, 32'h0);
    reg_op(1'b0, 12'h800, 32'h0, 32'h0);
    idle(1);
    {sec_impl, observe, shared} = 3'b011;
    idle(2);
    reg_op(1'b1, 12'h400, 32'hFFFF_FFFF, 32'h0);
    reg_op(1'b0, 12'h400, 32'h0, 32'h2007_FFFF);
    reg_op(1'b0, 12'h404, 32'h0, 32'h0000_0011);
    idle(1);
    for (int i = 0; i < 20 && (rq.size() || eq.size()); i++)
      @(negedge clock_i);
    if (rq.size() || eq.size())
      fail_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
